// >>> rtl/dbrt_consts.vh
// Constants for the dual push-button reset timer.
// Assumes a 250 MHz system clock; all counts are derived from it.
`ifndef DBRT_CONSTS_VH
`define DBRT_CONSTS_VH

// System clock rate in kHz, so that cycles = milliseconds * rate.
`define DBRT_CLK_KHZ          250000

// Set-up delays in milliseconds and their cycle counts.
`define DBRT_SETUP_SHORT_MS   2000
`define DBRT_SETUP_MID_MS     4000
`define DBRT_SETUP_LONG_MS    6000
`define DBRT_SETUP_SHORT_CYC  (`DBRT_SETUP_SHORT_MS * `DBRT_CLK_KHZ)
`define DBRT_SETUP_MID_CYC    (`DBRT_SETUP_MID_MS * `DBRT_CLK_KHZ)
`define DBRT_SETUP_LONG_CYC   (`DBRT_SETUP_LONG_MS * `DBRT_CLK_KHZ)

// Reset timeout options in milliseconds (least values) and cycles.
`define DBRT_TIMEOUT_X_MS     140
`define DBRT_TIMEOUT_Y_MS     240
`define DBRT_TIMEOUT_X_CYC    (`DBRT_TIMEOUT_X_MS * `DBRT_CLK_KHZ)
`define DBRT_TIMEOUT_Y_CYC    (`DBRT_TIMEOUT_Y_MS * `DBRT_CLK_KHZ)

// Factory option codes for the timeout.
`define DBRT_OPT_X            1'b0
`define DBRT_OPT_Y            1'b1

// Sensed codes of the three-state delay select pin {high_seen, low_seen}.
`define DBRT_SEL_GROUND       2'h0
`define DBRT_SEL_FLOAT        2'h1
`define DBRT_SEL_RAIL         2'h3

// Width of the cycle counter.
`define DBRT_CNT_W            32

// Synchroniser depth for pin inputs.
`define DBRT_SYNC_DEPTH       3

`endif

// >>> rtl/dbrt_reset_timer.v
// Dual push-button reset timer: two manual reset buttons held together
// for a selectable set-up delay start one fixed-length reset pulse.
// Assumes buttons, delay select strap and pull-ups sit outside the chip;
// the open-drain output's wire level is resolved by the surroundings.
//
// Contract
// RULE1: Reset starts only after both inputs held long.
// RULE2: Select pin picks 2, 4 or 6 s.
// RULE3: Timeout fixed factory option, 140 or 240 ms.
// RULE4: High-active output high for timeout after set-up.
// RULE5: Low-active output driven low, else floats.
// RULE6: One pulse per hold, even if held on.
// RULE7: Unused input tied high; inputs may be joined.
// RULE8: Early release abandons count, restarts from zero.
`timescale 1ns/10ps
`include "dbrt_consts.vh"

module dbrt_reset_timer #(
    parameter [`DBRT_CNT_W-1:0] SETUP_SHORT_CYCLES = `DBRT_SETUP_SHORT_CYC,
    parameter [`DBRT_CNT_W-1:0] SETUP_MID_CYCLES   = `DBRT_SETUP_MID_CYC,
    parameter [`DBRT_CNT_W-1:0] SETUP_LONG_CYCLES  = `DBRT_SETUP_LONG_CYC,
    parameter [0:0]             TIMEOUT_OPTION     = `DBRT_OPT_X,
    parameter [`DBRT_CNT_W-1:0] TIMEOUT_X_CYCLES   = `DBRT_TIMEOUT_X_CYC,
    parameter [`DBRT_CNT_W-1:0] TIMEOUT_Y_CYCLES   = `DBRT_TIMEOUT_Y_CYC
) (
    input  wire       sys_clk,
    input  wire       rst,
    input  wire       clk_en,
    input  wire       manual_reset_in_a_n,
    input  wire       manual_reset_in_b_n,
    input  wire [1:0] setup_delay_select,
    output reg        reset_out_high_active,
    output reg        reset_out_low_active,
    output reg        reset_out_low_active_oe_n
);

    // Controller states.
    localparam [1:0] ST_IDLE    = 2'h0;
    localparam [1:0] ST_COUNT   = 2'h1;
    localparam [1:0] ST_PULSE   = 2'h2;
    localparam [1:0] ST_RELEASE = 2'h3;

    // Number of pin inputs that pass the synchroniser.
    localparam integer N_PINS = 4;

    // The timeout is settled at build time and cannot move while running.
    // RULE3: fixed timeout option
    localparam [`DBRT_CNT_W-1:0] TIMEOUT_CYCLES =
        (TIMEOUT_OPTION == `DBRT_OPT_Y) ? TIMEOUT_Y_CYCLES : TIMEOUT_X_CYCLES;

    // Map the sensed select code onto a set-up delay in cycles.
    // An undefined code (high seen but low not) is taken as floating,
    // the shortest delay, since a marginal strap most likely floats.
    function [`DBRT_CNT_W-1:0] setup_cycles;
        input [1:0] sel;
        begin
            case (sel)
                `DBRT_SEL_GROUND: setup_cycles = SETUP_MID_CYCLES;
                `DBRT_SEL_RAIL:   setup_cycles = SETUP_LONG_CYCLES;
                `DBRT_SEL_FLOAT:  setup_cycles = SETUP_SHORT_CYCLES;
                default:          setup_cycles = SETUP_SHORT_CYCLES;
            endcase
        end
    endfunction

    // Raw pin vector: button A, button B, select bits.
    wire [N_PINS-1:0] pin_raw;

    assign pin_raw = {setup_delay_select, manual_reset_in_b_n, manual_reset_in_a_n};

    // Synchroniser stages and the filtered, agreed pin levels.
    reg  [N_PINS-1:0] sync_s1;
    reg  [N_PINS-1:0] sync_s2;
    reg  [N_PINS-1:0] sync_s3;
    reg  [N_PINS-1:0] pin_clean;

    // Each pin passes three flops; the clean level follows only once the
    // second and third stages agree, which also rejects a one-cycle glitch.
    // Buttons reset to the released level so no pulse can start at reset.
    genvar gi;
    generate
        for (gi = 0; gi < N_PINS; gi = gi + 1)
        begin : g_sync
            always @(posedge sys_clk)
            begin
                if (rst)
                begin
                    sync_s1[gi]   <= 1'b1;
                    sync_s2[gi]   <= 1'b1;
                    sync_s3[gi]   <= 1'b1;
                    pin_clean[gi] <= 1'b1;
                end
                else if (clk_en)
                begin
                    sync_s1[gi] <= pin_raw[gi];
                    sync_s2[gi] <= sync_s1[gi];
                    sync_s3[gi] <= sync_s2[gi];
                    if (sync_s2[gi] == sync_s3[gi])
                    begin
                        pin_clean[gi] <= sync_s3[gi];
                    end
                end
            end
        end
    endgenerate

    // Both buttons pressed; a single button wired to both pins works too.
    wire       both_low;
    wire [1:0] sel_clean;

    assign both_low  = ~pin_clean[0] & ~pin_clean[1];
    assign sel_clean = pin_clean[3:2];

    // Controller state, cycle counter and the delay latched for this hold.
    reg  [1:0]             state;
    reg  [1:0]             next_state;
    reg  [`DBRT_CNT_W-1:0] cnt;
    reg  [`DBRT_CNT_W-1:0] next_cnt;
    reg  [`DBRT_CNT_W-1:0] delay;
    reg  [`DBRT_CNT_W-1:0] next_delay;
    reg                    next_pulse;

    // Next-state logic. The delay is latched when a hold begins, so that a
    // strap changing mid-hold cannot shorten a count already running.
    always @*
    begin
        next_state = state;
        next_cnt   = cnt;
        next_delay = delay;
        next_pulse = 1'b0;
        case (state)
            ST_IDLE:
            begin
                // RULE2: delay from select
                next_delay = setup_cycles(sel_clean);
                if (both_low)
                begin
                    next_state = ST_COUNT;
                    next_cnt   = {{(`DBRT_CNT_W-1){1'b0}}, 1'b1};
                end
                else
                begin
                    next_cnt = {`DBRT_CNT_W{1'b0}};
                end
            end
            ST_COUNT:
            begin
                // RULE8: release abandons count
                if (!both_low)
                begin
                    next_state = ST_IDLE;
                    next_cnt   = {`DBRT_CNT_W{1'b0}};
                end
                // RULE1: held longer than delay
                else if (cnt >= delay)
                begin
                    next_state = ST_PULSE;
                    next_cnt   = {{(`DBRT_CNT_W-1){1'b0}}, 1'b1};
                    next_pulse = 1'b1;
                end
                else
                begin
                    next_cnt = cnt + {{(`DBRT_CNT_W-1){1'b0}}, 1'b1};
                end
            end
            ST_PULSE:
            begin
                // RULE4: hold for timeout
                if (cnt >= TIMEOUT_CYCLES)
                begin
                    next_state = ST_RELEASE;
                    next_cnt   = {`DBRT_CNT_W{1'b0}};
                end
                else
                begin
                    next_cnt   = cnt + {{(`DBRT_CNT_W-1){1'b0}}, 1'b1};
                    next_pulse = 1'b1;
                end
            end
            ST_RELEASE:
            begin
                // RULE6: no retrigger while held
                if (!both_low)
                begin
                    next_state = ST_IDLE;
                end
            end
            default:
            begin
                next_state = ST_IDLE;
                next_cnt   = {`DBRT_CNT_W{1'b0}};
            end
        endcase
    end

    // State registers and output flops. The outputs are registered so
    // that no decode glitch can ever reach a reset pin downstream.
    always @(posedge sys_clk)
    begin
        if (rst)
        begin
            state                     <= ST_IDLE;
            cnt                       <= {`DBRT_CNT_W{1'b0}};
            delay                     <= SETUP_SHORT_CYCLES;
            reset_out_high_active     <= 1'b0;
            reset_out_low_active      <= 1'b0;
            reset_out_low_active_oe_n <= 1'b1;
        end
        else if (clk_en)
        begin
            state <= next_state;
            cnt   <= next_cnt;
            delay <= next_delay;
            // RULE4: high-active pulse
            reset_out_high_active     <= next_pulse;
            // RULE5: open-drain low pulse
            reset_out_low_active      <= 1'b0;
            reset_out_low_active_oe_n <= ~next_pulse;
        end
    end

endmodule // dbrt_reset_timer

// >>> tb/dbrt_host_model.sv
// Far side: a controller reset input behind the two reset outputs.
// Assumes a pull-up on the open-drain line and nothing else on it.
`timescale 1ns/10ps
module dbrt_host_model (
    input  wire od_data,
    input  wire od_oe_n,
    input  wire high_in,
    output wire line_n,
    output wire in_reset
);
    assign line_n = od_oe_n ? 1'b1 : od_data;
    // Held in reset while either output asks for it.
    assign in_reset = !line_n || high_in;
endmodule // dbrt_host_model

// >>> tb/dbrt_testbench.sv
// Testbench for the reset timer, with short delays: 20/40/60, timeout 10.
// Assumes buttons and clk_en are driven on the falling clock edge.
`timescale 1ns/10ps
module testbench;
    logic       sys_clk = 1'b0;
    logic       rst = 1'b1;
    logic       a_n = 1'b1;
    logic       b_n = 1'b1;
    logic [1:0] sel = 2'h1;
    logic       clk_en = 1'b1;
    wire        high, od, oe_n, line_n, in_reset;
    int         failures = 0;
    int         check_count = 0;
    dbrt_reset_timer #(.SETUP_SHORT_CYCLES(20), .SETUP_MID_CYCLES(40),
        .SETUP_LONG_CYCLES(60), .TIMEOUT_X_CYCLES(10), .TIMEOUT_Y_CYCLES(15)) dut_u (
        .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .manual_reset_in_a_n(a_n),
        .manual_reset_in_b_n(b_n), .setup_delay_select(sel),
        .reset_out_high_active(high), .reset_out_low_active(od),
        .reset_out_low_active_oe_n(oe_n));
    dbrt_host_model model_u (.od_data(od), .od_oe_n(oe_n), .high_in(high),
        .line_n(line_n), .in_reset(in_reset));
    // Clock of 4 ns.
    initial
    begin
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic idle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    begin
        check_count++;
        if (exp !== got)
        begin
            failures++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    end
    endtask
    task automatic close_out;
    begin
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask
    // Counts reset cycles seen by the far side over a span.
    task automatic quiet(input string what, input int span);
        int n;
    begin
        n = 0;
        repeat (span) begin @(negedge sys_clk); n += (in_reset !== 1'b0); end
        chk(what, 0, n);
    end
    endtask
    // Full hold: set-up delay, pulse length, no re-fire while held.
    task automatic hold_pulse(input logic [1:0] code, input int d);
        int n;
    begin
        sel = code;
        a_n = 1'b0;
        b_n = 1'b0;
        n = 0;
        while (high !== 1'b1 && n < 400) begin idle(1); n++; end
        if (n == 400) begin failures++; close_out(); end
        chk("setup", d, (n > d && n <= d + 8) ? d : n);
        n = 0;
        while (high === 1'b1 && line_n === 1'b0 && n < 100) begin idle(1); n++; end
        chk("timeout", 10, n);
        if (n == 100) close_out();
        quiet("held", 30);
        a_n = 1'b1;
        b_n = 1'b1;
        idle(8);
    end
    endtask
    // Every select code, the undefined one read as floating.
    task automatic t_modes;
        logic [1:0] codes [4] = '{2'h1, 2'h0, 2'h3, 2'h2};
        int         dels [4] = '{20, 40, 60, 20};
        for (int i = 0; i < 4; i++) hold_pulse(codes[i], dels[i]);
    endtask
    // Early release abandons the count; the next hold starts from zero.
    task automatic t_abort;
    begin
        a_n = 1'b0;
        b_n = 1'b0;
        // Release well before the pulse could fire, allowing for the pin filter.
        idle(12);
        b_n = 1'b1;
        quiet("abort", 10);
        hold_pulse(2'h1, 20);
    end
    endtask
    // Enable low freezes the count; the hold resumes where it stood.
    task automatic t_freeze;
        int n;
    begin
        sel = 2'h1;
        a_n = 1'b0;
        b_n = 1'b0;
        idle(10);
        clk_en = 1'b0;
        quiet("frozen", 40);
        clk_en = 1'b1;
        n = 0;
        while (high !== 1'b1 && n < 100) begin idle(1); n++; end
        if (n == 100) begin failures++; close_out(); end
        chk("resume", 15, n);
        a_n = 1'b1;
        b_n = 1'b1;
        idle(20);
    end
    endtask
    // One button alone never starts a reset; the other stays at its idle level.
    task automatic t_single;
    begin
        a_n = 1'b0;
        quiet("single", 80);
        a_n = 1'b1;
        idle(8);
    end
    endtask
    initial
    begin
        idle(5);
        rst = 1'b0;
        chk("idle line", 1, line_n);
        t_modes();
        t_abort();
        t_single();
        t_freeze();
        close_out();
    end
endmodule // testbench
bind dbrt_reset_timer dbrt_timer_props props_u (
    .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
    .manual_reset_in_a_n(manual_reset_in_a_n), .manual_reset_in_b_n(manual_reset_in_b_n),
    .setup_delay_select(setup_delay_select), .reset_out_high_active(reset_out_high_active),
    .reset_out_low_active(reset_out_low_active),
    .reset_out_low_active_oe_n(reset_out_low_active_oe_n));

// >>> tb/dbrt_timer_properties.sv
// Checker for the reset timer: pulse shape, length and polarity.
// Assumes clk_en may drop; only enabled edges count, as the timer then stands still.
`timescale 1ns/10ps
module dbrt_timer_props #(
    parameter int SHORT = 20,
    parameter int TO    = 10
) (
    input wire       sys_clk,
    input wire       rst,
    input wire       clk_en,
    input wire       manual_reset_in_a_n,
    input wire       manual_reset_in_b_n,
    input wire [1:0] setup_delay_select,
    input wire       reset_out_high_active,
    input wire       reset_out_low_active,
    input wire       reset_out_low_active_oe_n
);
    int   low_cnt;
    int   hi_cnt;
    logic pulsed;
    wire  up = manual_reset_in_a_n | manual_reset_in_b_n;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Hold length and pulse length in enabled edges, and whether this hold already fired.
    always @(posedge sys_clk)
    begin
        low_cnt <= (rst || up) ? 0 : low_cnt + int'(clk_en);
        hi_cnt <= (!rst && reset_out_high_active) ? hi_cnt + int'(clk_en) : 0;
        pulsed <= (rst || up) ? 1'b0 : (pulsed | reset_out_high_active);
    end
    sequence pulse_on;
        (reset_out_high_active && !reset_out_low_active_oe_n) [*8];
    endsequence
    outs_agree_a: assert property (reset_out_high_active == !reset_out_low_active_oe_n)
        else $error("outputs disagree");
    od_data_low_a: assert property (!reset_out_low_active)
        else $error("open-drain data not low");
    pulse_len_a: assert property ($fell(reset_out_high_active) |-> hi_cnt == TO)
        else $error("pulse length wrong");
    pulse_hold_a: assert property ($rose(reset_out_high_active) |-> pulse_on)
        else $error("pulse not held");
    hold_first_a: assert property ($rose(reset_out_high_active) |-> low_cnt > SHORT)
        else $error("pulse before full hold");
    one_pulse_a: assert property ($rose(reset_out_high_active) |-> !pulsed)
        else $error("second pulse in one hold");
    reset_quiet_a: assert property (disable iff (1'b0) rst |=> reset_out_low_active_oe_n)
        else $error("output active after reset");
endmodule // dbrt_timer_props
